// ---- shared/dtcc_pkg.sv ----
// Purpose: Constants and types for the dual time base capture/compare unit
// Assumes: One clock, 125 MHz; a clock cycle lasts two basic clock periods
package dtcc_pkg;
  localparam int DTCC_NUM_CH = 8;
  localparam int DTCC_TMR_W = 16;
  localparam int DTCC_TCL_PER_TICK = 16;
  localparam int DTCC_TCL_PER_CLK = 2;
  localparam int DTCC_TICK_CYC = DTCC_TCL_PER_TICK / DTCC_TCL_PER_CLK;
  localparam logic [15:0] DTCC_TMR_RST = 16'h0000;
  localparam logic [15:0] DTCC_TMR_MAX = 16'hFFFF;
  localparam logic [15:0] DTCC_CH_RST = 16'h0000;
  localparam logic [1:0] DTCC_EDGE_RISE = 2'h1;
  localparam logic [1:0] DTCC_EDGE_FALL = 2'h2;
  typedef enum logic [2:0] {
    DTCC_OFF = 3'h0,
    DTCC_CAPTURE = 3'h1,
    DTCC_CMP0 = 3'h4,
    DTCC_CMP1 = 3'h5,
    DTCC_CMP2 = 3'h6,
    DTCC_CMP3 = 3'h7
  } dtcc_mode_type;
endpackage

// ---- hdl/dtcc_unit.sv ----
// Purpose: Eight channel capture/compare unit with two reloadable time bases
// Assumes: Pins are asynchronous; configuration inputs are on clk_sys
// Notes: Channel i below NUM_CH/2 pairs with channel i+NUM_CH/2 in double mode
module dtcc_unit
  import dtcc_pkg::*;
#(
  parameter int NUM_CH = DTCC_NUM_CH,
  parameter int TICK_CYC = DTCC_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] tmr_run,
  input wire logic [15:0] tmr_reload_0,
  input wire logic [15:0] tmr_reload_1,
  input wire logic [NUM_CH-1:0][2:0] ch_mode,
  input wire logic [NUM_CH-1:0] ch_tmr_sel,
  input wire logic [NUM_CH-1:0][1:0] ch_edge_sel,
  input wire logic [NUM_CH/2-1:0] dbl_en,
  input wire logic [NUM_CH-1:0] ch_wr_en,
  input wire logic [15:0] ch_wr_data,
  input wire logic [NUM_CH-1:0] pin_in,
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe,
  output logic [NUM_CH-1:0] ch_irq,
  output logic [NUM_CH-1:0][15:0] ch_value,
  output logic [15:0] tmr_value_0,
  output logic [15:0] tmr_value_1,
  output logic [1:0] tmr_ovf
);
  localparam int HALF = NUM_CH / 2;
  localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  // Pairing needs an even channel count; the prescaler needs a period
  if (NUM_CH < 2 || NUM_CH % 2 != 0 || TICK_CYC < 1) begin : g_bad_param
    $error("dtcc_unit: unsupported parameter values");
  end

  logic [1:0] rst_sync_ff;
  logic rst_int_n;
  logic [TW-1:0] tick_ff, nxt_tick;
  logic tick_now;
  logic [15:0] tmr_ff [2];
  logic [15:0] nxt_tmr [2];
  logic [15:0] reload [2];
  logic [1:0] tmr_upd_ff, nxt_tmr_upd;
  logic [1:0] tmr_ovf_ff, nxt_tmr_ovf;
  logic [NUM_CH-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic [NUM_CH-1:0][15:0] ch_reg_ff, nxt_ch_reg;
  logic [NUM_CH-1:0] fired_ff, nxt_fired;
  logic [NUM_CH-1:0] pin_out_ff, nxt_pin_out;
  logic [NUM_CH-1:0] pin_oe_ff, nxt_pin_oe;
  logic [NUM_CH-1:0] ch_irq_ff, nxt_ch_irq;
  logic [NUM_CH-1:0] match, cap_ev, fire, pair_match, dbl_full, period_end;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_ff[1];
  assign reload[0] = tmr_reload_0;
  assign reload[1] = tmr_reload_1;
  assign tick_now = (tick_ff == TICK_LAST);

  // Time bases
  always_comb begin
    nxt_tick = tick_now ? '0 : tick_ff + TW'(1);
    for (int t = 0; t < 2; t++) begin
      nxt_tmr[t] = tmr_ff[t];
      nxt_tmr_upd[t] = 1'b0;
      nxt_tmr_ovf[t] = 1'b0;
      if (tick_now && tmr_run[t]) begin
        nxt_tmr_upd[t] = 1'b1;
        if (tmr_ff[t] == DTCC_TMR_MAX) begin
          nxt_tmr[t] = reload[t];
          nxt_tmr_ovf[t] = 1'b1;
        end else begin
          nxt_tmr[t] = tmr_ff[t] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tick_ff <= '0;
      tmr_ff[0] <= DTCC_TMR_RST;
      tmr_ff[1] <= DTCC_TMR_RST;
      tmr_upd_ff <= 2'h0;
      tmr_ovf_ff <= 2'h0;
    end else begin
      tick_ff <= nxt_tick;
      tmr_ff[0] <= nxt_tmr[0];
      tmr_ff[1] <= nxt_tmr[1];
      tmr_upd_ff <= nxt_tmr_upd;
      tmr_ovf_ff <= nxt_tmr_ovf;
    end
  end

  // Pin synchronisers; third stage only holds the previous level
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Channel array
  always_comb begin
    dbl_full = '0;
    dbl_full[HALF-1:0] = dbl_en;
    pair_match = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      logic [15:0] tv;
      logic is_cmp, single, rise, fall;
      tv = tmr_ff[ch_tmr_sel[i]];
      is_cmp = ch_mode[i][2];
      single = (ch_mode[i] == DTCC_CMP2) || (ch_mode[i] == DTCC_CMP3);
      rise = pin_s2_ff[i] && !pin_s3_ff[i];
      fall = !pin_s2_ff[i] && pin_s3_ff[i];
      period_end[i] = tmr_ovf_ff[ch_tmr_sel[i]];
      cap_ev[i] = (ch_mode[i] == DTCC_CAPTURE) &&
        ((ch_edge_sel[i][0] && rise) || (ch_edge_sel[i][1] && fall));
      // Only the cycle after a timer step compares
      match[i] = is_cmp && tmr_upd_ff[ch_tmr_sel[i]] &&
        (ch_reg_ff[i] == tv);
      nxt_fired[i] = period_end[i] ? 1'b0 : fired_ff[i];
      fire[i] = match[i] && !(single && nxt_fired[i]);
      if (fire[i] && single) begin
        nxt_fired[i] = 1'b1;
      end
      nxt_ch_reg[i] = ch_reg_ff[i];
      if (cap_ev[i]) begin
        nxt_ch_reg[i] = tv;
      end else if (ch_wr_en[i]) begin
        nxt_ch_reg[i] = ch_wr_data;
      end
      nxt_ch_irq[i] = cap_ev[i] || fire[i];
    end
    for (int j = 0; j < HALF; j++) begin
      pair_match[j] = match[j + HALF];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_pin_out[i] = pin_out_ff[i];
      nxt_pin_oe[i] = (ch_mode[i] == DTCC_CMP1) ||
        (ch_mode[i] == DTCC_CMP3) || dbl_full[i];
      if (dbl_full[i]) begin
        if (match[i] ^ pair_match[i]) begin
          nxt_pin_out[i] = !pin_out_ff[i];
        end
      end else if (ch_mode[i] == DTCC_CMP1) begin
        if (match[i]) begin
          nxt_pin_out[i] = !pin_out_ff[i];
        end
      end else if (ch_mode[i] == DTCC_CMP3) begin
        if (fire[i]) begin
          nxt_pin_out[i] = 1'b1;
        end else if (period_end[i]) begin
          nxt_pin_out[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ch_reg_ff <= {NUM_CH{DTCC_CH_RST}};
      fired_ff <= '0;
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      ch_irq_ff <= '0;
    end else begin
      ch_reg_ff <= nxt_ch_reg;
      fired_ff <= nxt_fired;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      ch_irq_ff <= nxt_ch_irq;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign ch_irq = ch_irq_ff;
  assign ch_value = ch_reg_ff;
  assign tmr_value_0 = tmr_ff[0];
  assign tmr_value_1 = tmr_ff[1];
  assign tmr_ovf = tmr_ovf_ff;

  // Checks on timer 0
  property p_tick_spacing;
    @(posedge clk_sys) disable iff (!rst_int_n)
      tmr_upd_ff[0] |=> !tmr_upd_ff[0] [*7];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("timer stepped faster than the tick");

  property p_reload;
    @(posedge clk_sys) disable iff (!rst_int_n)
      tmr_ovf_ff[0] |-> tmr_ff[0] == $past(tmr_reload_0);
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer did not take its reload value");

  // Per-channel checks, so every channel that a test uses is watched
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    property p_capture_value;
      @(posedge clk_sys) disable iff (!rst_int_n)
        cap_ev[g] |=> ch_value[g] == $past(tmr_ff[ch_tmr_sel[g]]);
    endproperty
    a_capture_value: assert property (p_capture_value)
      else $error("capture stored the wrong timer value");

    property p_capture_irq;
      @(posedge clk_sys) disable iff (!rst_int_n)
        cap_ev[g] |=> ch_irq[g];
    endproperty
    a_capture_irq: assert property (p_capture_irq)
      else $error("capture raised no interrupt");

    property p_capture_edge;
      @(posedge clk_sys) disable iff (!rst_int_n)
        cap_ev[g] |-> pin_s2_ff[g] != pin_s3_ff[g] &&
          (pin_s2_ff[g] ? ch_edge_sel[g][0] : ch_edge_sel[g][1]);
    endproperty
    a_capture_edge: assert property (p_capture_edge)
      else $error("capture without a selected edge");

    property p_write;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_wr_en[g] && !cap_ev[g] |=> ch_value[g] == $past(ch_wr_data);
    endproperty
    a_write: assert property (p_write)
      else $error("channel write did not land");

    property p_irq_cause;
      @(posedge clk_sys) disable iff (!rst_int_n)
        !cap_ev[g] && !match[g] |=> !ch_irq[g];
    endproperty
    a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without capture or match");

    property p_mode0_pin;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_mode[g] == DTCC_CMP0 && !dbl_full[g] |=> !pin_oe[g];
    endproperty
    a_mode0_pin: assert property (p_mode0_pin)
      else $error("mode 0 drives its pin");

    property p_toggle;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_mode[g] == DTCC_CMP1 && !dbl_full[g] && match[g]
          |=> pin_out[g] != $past(pin_out[g]) && ch_irq[g];
    endproperty
    a_toggle: assert property (p_toggle)
      else $error("mode 1 match did not toggle the pin");

    property p_once;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_mode[g] == DTCC_CMP2 && fired_ff[g] && !period_end[g]
          |=> !ch_irq[g];
    endproperty
    a_once: assert property (p_once)
      else $error("mode 2 interrupted twice in one period");

    property p_mode2_pin;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_mode[g] == DTCC_CMP2 && !dbl_full[g] |=> !pin_oe[g];
    endproperty
    a_mode2_pin: assert property (p_mode2_pin)
      else $error("mode 2 drives its pin");

    property p_mode3_set;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_mode[g] == DTCC_CMP3 && !dbl_full[g] && fire[g] |=> pin_out[g];
    endproperty
    a_mode3_set: assert property (p_mode3_set)
      else $error("mode 3 pin not set on match");

    property p_mode3_clear;
      @(posedge clk_sys) disable iff (!rst_int_n)
        ch_mode[g] == DTCC_CMP3 && !dbl_full[g] && period_end[g] &&
          !fire[g] |=> !pin_out[g];
    endproperty
    a_mode3_clear: assert property (p_mode3_clear)
      else $error("mode 3 pin not cleared on overflow");

    property p_double_toggle;
      @(posedge clk_sys) disable iff (!rst_int_n)
        dbl_full[g] && (match[g] ^ pair_match[g])
          |=> pin_out[g] != $past(pin_out[g]);
    endproperty
    a_double_toggle: assert property (p_double_toggle)
      else $error("double mode match did not toggle the pin");

    property p_single_match;
      @(posedge clk_sys) disable iff (!rst_int_n)
        match[g] |=> !match[g];
    endproperty
    a_single_match: assert property (p_single_match)
      else $error("one timer value matched twice");
  end

endmodule // dtcc_unit

// ---- verif/dtcc_pin_model.sv ----
// Purpose: Pin side model: external drivers on the channel pins
// Assumes: A pin the unit drives reads back its own output level
// Notes: Undriven pins follow the level that the bench sets
module dtcc_pin_model #(
  parameter int NUM_CH = 8
) (
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe,
  input wire logic [NUM_CH-1:0] ext_lvl,
  output logic [NUM_CH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // dtcc_pin_model

// ---- verif/test_dtcc_unit.sv ----
// Purpose: Self-checking bench for the capture/compare unit
// Assumes: Timer overflow takes 2^19 cycles, so it is not reached here
// Notes: Captures are taken with the chosen timer halted
module test_dtcc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] tmr_run = 2'h0;
  logic [15:0] tmr_reload_0 = 16'h0000;
  logic [15:0] tmr_reload_1 = 16'h0000;
  logic [7:0][2:0] ch_mode = '0;
  logic [7:0] ch_tmr_sel = 8'h00;
  logic [7:0][1:0] ch_edge_sel = '0;
  logic [3:0] dbl_en = 4'h0;
  logic [7:0] ch_wr_en = 8'h00;
  logic [15:0] ch_wr_data = 16'h0000;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] pin_in, pin_out, pin_oe, ch_irq;
  logic [7:0][15:0] ch_value;
  logic [15:0] tmr_value_0, tmr_value_1;
  logic [1:0] tmr_ovf;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 clk_sys = ~clk_sys;
  dtcc_unit dut (.clk_sys, .rst_n, .tmr_run, .tmr_reload_0, .tmr_reload_1,
    .ch_mode, .ch_tmr_sel, .ch_edge_sel, .dbl_en, .ch_wr_en, .ch_wr_data,
    .pin_in, .pin_out, .pin_oe, .ch_irq, .ch_value, .tmr_value_0,
    .tmr_value_1, .tmr_ovf);
  dtcc_pin_model pins (.pin_out, .pin_oe, .ext_lvl, .pin_in);
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic count_irq(int ch, int m, output int n);
    n = 0;
    repeat (m) begin
      @(posedge clk_sys);
      #1;
      if (ch_irq[ch] === 1'b1) n++;
    end
  endtask
  task automatic step_wait(output int k);
    logic [15:0] v;
    v = tmr_value_0;
    k = 0;
    while (tmr_value_0 === v && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask
  task automatic arm(int ch, logic [2:0] mode, logic [15:0] val);
    @(posedge clk_sys);
    ch_wr_en[ch] <= 1'b1;
    ch_wr_data <= val;
    ch_mode[ch] <= mode;
    @(posedge clk_sys);
    ch_wr_en[ch] <= 1'b0;
  endtask
  task automatic t_timer();
    logic [15:0] v;
    int k;
    @(posedge clk_sys);
    tmr_run <= 2'h1;
    step_wait(k);
    v = tmr_value_0;
    step_wait(k);
    check("tick spacing", 16'(dtcc_pkg::DTCC_TICK_CYC), 16'(k));
    check("timer step", v + 16'h0001, tmr_value_0);
    check("idle timer", 16'h0000, tmr_value_1);
  endtask
  task automatic t_capture();
    logic [15:0] v;
    int n, m;
    @(posedge clk_sys);
    tmr_run <= 2'h0;
    repeat (3) @(posedge clk_sys);
    v = tmr_value_0;
    for (int e = 1; e <= 3; e++) begin
      ch_edge_sel[1] <= 2'(e);
      arm(1, 3'h1, 16'h0000);
      ext_lvl[1] <= 1'b1;
      count_irq(1, 12, n);
      ext_lvl[1] <= 1'b0;
      count_irq(1, 12, m);
      check("edge irqs", (e == 3) ? 16'h0002 : 16'h0001, 16'(n + m));
      check("captured", v, ch_value[1]);
    end
    ch_tmr_sel[3] <= 1'b1;
    ch_edge_sel[3] <= 2'h1;
    arm(3, 3'h1, 16'h1234);
    ext_lvl[3] <= 1'b1;
    count_irq(3, 12, n);
    check("capture irq", 16'h0001, 16'(n));
    check("capture timer1", 16'h0000, ch_value[3]);
  endtask
  task automatic t_compare();
    logic [15:0] t;
    logic [15:0] e;
    logic p;
    int n;
    tmr_run <= 2'h1;
    for (int md = 4; md <= 7; md++) begin
      ch_tmr_sel[md-2] <= 1'b0;
      p = pin_out[md-2];
      // Second match in the same timer period: modes 2 and 3 stay quiet
      for (int r = 0; r < 2; r++) begin
        t = tmr_value_0 + 16'h0003;
        e = (r == 1 && md >= 6) ? 16'h0000 : 16'h0001;
        arm(md - 2, 3'(md), t);
        count_irq(md - 2, 40, n);
        check("irqs", e, 16'(n));
        check("written", t, ch_value[md-2]);
        check("pin enable", 16'(md & 1), 16'(pin_oe[md-2]));
        if (md == 5)
          check("toggle", 16'(p ^ (r == 0)), 16'(pin_out[md-2]));
        if (md == 7)
          check("set pin", 16'h0001, 16'(pin_out[md-2]));
      end
    end
  endtask
  task automatic t_double();
    logic [15:0] t;
    logic p;
    int n;
    @(posedge clk_sys);
    dbl_en <= 4'h1;
    t = tmr_value_0;
    arm(0, 3'h5, t + 16'h0003);
    arm(4, 3'h5, t + 16'h0007);
    p = pin_out[0];
    count_irq(0, 32, n);
    check("lower irq", 16'h0001, 16'(n));
    check("lower toggle", 16'(!p), 16'(pin_out[0]));
    count_irq(4, 32, n);
    check("upper irq", 16'h0001, 16'(n));
    check("upper toggle", 16'(p), 16'(pin_out[0]));
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("reset timer", dtcc_pkg::DTCC_TMR_RST, tmr_value_0);
    check("reset value", dtcc_pkg::DTCC_CH_RST, ch_value[0]);
    t_timer();
    t_capture();
    t_compare();
    t_double();
    final_report();
  end
endmodule // test_dtcc_unit
